// ---- hdl/qen_pkg.sv ----
// Purpose: shared constants for the quadrature encoder block
// Assumes: 32-bit AHB-Lite word per register, index times four is the byte address
// Notes: mode codes, field positions, reset values and divider lookups
package qen_pkg;
  localparam logic [11:0] QEN_IDX_CTL = 12'h122;
  localparam logic [11:0] QEN_IDX_FLT = 12'h124;
  localparam logic [11:0] QEN_IDX_POS = 12'h126;
  localparam logic [11:0] QEN_IDX_MAX = 12'h128;
  localparam logic [11:0] QEN_IDX_IRQ = 12'h12A;
  localparam logic [31:0] QEN_ADDR_CTL = {18'h00000, QEN_IDX_CTL, 2'h0};
  localparam logic [31:0] QEN_ADDR_FLT = {18'h00000, QEN_IDX_FLT, 2'h0};
  localparam logic [31:0] QEN_ADDR_POS = {18'h00000, QEN_IDX_POS, 2'h0};
  localparam logic [31:0] QEN_ADDR_MAX = {18'h00000, QEN_IDX_MAX, 2'h0};
  localparam logic [31:0] QEN_ADDR_IRQ = {18'h00000, QEN_IDX_IRQ, 2'h0};
  localparam int QEN_CTL_SIDL = 13;
  localparam int QEN_CTL_INDEX_PIN_STATE = 12;
  localparam int QEN_CTL_DIR = 11;
  localparam int QEN_CTL_MODE = 8;
  localparam int QEN_CTL_SWAP = 7;
  localparam int QEN_CTL_DOE = 6;
  localparam int QEN_CTL_GATE = 5;
  localparam int QEN_CTL_PS = 3;
  localparam int QEN_CTL_SYNC = 2;
  localparam int QEN_CTL_CS = 1;
  localparam int QEN_CTL_DSRC = 0;
  localparam int QEN_FLT_PEN = 7;
  localparam int QEN_FLT_PDIV = 4;
  localparam int QEN_FLT_IEN = 3;
  localparam int QEN_FLT_IDIV = 0;
  localparam int QEN_IRQ_FLAG = 0;
  localparam int QEN_IRQ_EN = 1;
  localparam logic [15:0] QEN_CTL_RST = 16'h0000;
  localparam logic [15:0] QEN_FLT_RST = 16'h0000;
  localparam logic [15:0] QEN_POS_RST = 16'h0000;
  localparam logic [15:0] QEN_MAX_RST = 16'hFFFF;
  localparam logic [2:0] QEN_MODE_OFF = 3'h0;
  localparam logic [2:0] QEN_MODE_TMR = 3'h1;
  localparam logic [2:0] QEN_MODE_X2_IDX = 3'h4;
  localparam logic [2:0] QEN_MODE_X2_MAX = 3'h5;
  localparam logic [2:0] QEN_MODE_X4_IDX = 3'h6;
  localparam logic [2:0] QEN_MODE_X4_MAX = 3'h7;
  localparam logic [15:0] QEN_CNT_TOP = 16'hFFFF;
  localparam logic [15:0] QEN_CNT_ZERO = 16'h0000;
  localparam logic [1:0] QEN_HRESP_OKAY = 2'h0;

  typedef enum logic {QEN_BUS_IDLE, QEN_BUS_RD} qen_bus_t;

  // terminal counts: divide by 1,2,4,16,32,64,128,256
  function automatic logic [7:0] qen_div_tc(input logic [2:0] s);
    case (s)
      3'h0: qen_div_tc = 8'h00;
      3'h1: qen_div_tc = 8'h01;
      3'h2: qen_div_tc = 8'h03;
      3'h3: qen_div_tc = 8'h0F;
      3'h4: qen_div_tc = 8'h1F;
      3'h5: qen_div_tc = 8'h3F;
      3'h6: qen_div_tc = 8'h7F;
      default: qen_div_tc = 8'hFF;
    endcase
  endfunction

  // terminal counts: prescale 1,8,64,256
  function automatic logic [7:0] qen_ps_tc(input logic [1:0] s);
    case (s)
      2'h0: qen_ps_tc = 8'h00;
      2'h1: qen_ps_tc = 8'h07;
      2'h2: qen_ps_tc = 8'h3F;
      default: qen_ps_tc = 8'hFF;
    endcase
  endfunction
endpackage

// ---- hdl/qen_filt_if.sv ----
// Purpose: carries one noise filter channel between top and filter
// Assumes: raw input is already synchronised
// Notes: src side drives settings, flt side returns the filtered level
`timescale 1ns/10ps
interface qen_filt_if;
  logic raw;
  logic [2:0] div_sel;
  logic en;
  logic filt;
  modport src (output raw, output div_sel, output en, input filt);
  modport flt (input raw, input div_sel, input en, output filt);
endinterface

// ---- hdl/qen_filter.sv ----
// Purpose: three-sample digital noise filter with clock divider
// Assumes: raw input synchronised to clock
// Notes: bypassed (one flop of delay) while disabled
`timescale 1ns/10ps
module qen_filter import qen_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  qen_filt_if.flt port
);
  logic [7:0] div_q;
  logic [2:0] smp_q;
  logic out_q;
  logic tick;

  assign tick = (div_q == qen_div_tc(port.div_sel));
  assign port.filt = out_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
    end else if (tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      smp_q <= 3'h0;
    end else if (tick) begin
      smp_q <= {smp_q[1:0], port.raw};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else if (!port.en) begin
      out_q <= port.raw;
    end else if (smp_q[2] == smp_q[1] && smp_q[1] == smp_q[0]) begin
      out_q <= smp_q[0];
    end
  end

  a_filter_stable: assert property (@(posedge clock) disable iff (!rst_n)
    (port.en && $past(port.en) && out_q != $past(out_q)) |->
    ($past(smp_q) == {3{out_q}}))
    else $error("filter output moved without three equal samples");
endmodule

// ---- hdl/qen_top.sv ----
// Purpose: quadrature encoder interface with 16-bit position counter and timer
// Assumes: AHB-Lite slave, single word transfers, one clock
// Notes: pins pass two flops; reads take one wait state, writes none
// Summary of operation
// - flag sets on counter rollover or underflow and on timer period match.
// - flag stays set until software clears it.
// - end of gated time accumulation also raises the flag.
// - interrupt request passes only while enable bit is set.
// - stop-in-idle bit freezes the block while the processor idles.
// - read-only index bit shows the present index pin level.
// - direction bit reads one for up; writable only in timer mode.
// - mode 111 is x4 with match reset, 110 is x4 with index reset.
// - mode 101 is x2 with match reset, 100 is x2 with index reset.
// - mode 001 runs the timer, 000 and unused codes disable the block.
// - swap bit exchanges phase A and phase B before decoding.
// - direction output enable drives count direction onto the pin.
// - gate bit enables gated time accumulation in the timer.
// - timer prescale divides by 1, 8, 64 or 256.
// - clock source bit picks external pin rising edge or internal clock.
// - sync bit resynchronises external clock; ignored with internal clock.
// - in timer mode direction comes from phase B pin or direction bit.
// - phase filter enable routes A and B through noise filters.
// - filter divide field selects 1,2,4,16,32,64,128 or 256.
// - index filter has its own enable and same divide choices.
// - position counter is read/write and is the timer count.
// - maximum count is match value in match modes, period in timer mode.
// - count up when A leads B, down when A lags.
// - x4 steps on edges of both phases, x2 on phase A only.
// - filter output changes after three stable filter clock samples.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
module qen_top import qen_pkg::*; (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  input wire logic timer_ext_clock_pin,
  input wire logic timer_gate_input,
  input wire logic cpu_idle,
  output logic dir_out,
  output logic dir_oe,
  output logic encoder_irq
);
  logic rst_s1_q, rst_n_q;
  logic [4:0] pin_s1_q, pin_s2_q;
  logic sidl_q, swap_q, doe_q, gate_en_q, sync_q, cs_q, dsrc_q;
  logic [2:0] mode_q;
  logic [1:0] ps_sel_q;
  logic pen_q, ien_q;
  logic [2:0] pdiv_q, idiv_q;
  logic [15:0] pos_q, max_q;
  logic dir_q, flag_q, irq_en_q, idx_st_q;
  logic qa_q, qb_q, idx_prev_q, tck_prev_q, tck_rise_q, gate_prev_q;
  logic [7:0] ps_q;
  qen_bus_t st_q;
  logic wr_q;
  logic [4:0] sel_q;
  logic [31:0] rdata_w;
  logic [4:0] sel_w;
  logic addr_ok, wr_ctl, wr_flt, wr_pos, wr_max, wr_irq;
  logic fa, fb, fi, qa, qb, a_edge, b_edge, up_w;
  logic enc_mode, x4, match, tmr_mode, halt, enc_step, idx_rst;
  logic tck_rise, src_tick, gate_ok, ps_tick, tmr_up, tmr_tick, gate_evt;
  logic enc_evt, tmr_evt, evt;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // pins cross in through two flops
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
    end else begin
      pin_s1_q <= {timer_gate_input, timer_ext_clock_pin, index_input, phase_b_input,
                   phase_a_input};
      pin_s2_q <= pin_s1_q;
    end
  end

  qen_filt_if fa_if();
  qen_filt_if fb_if();
  qen_filt_if fi_if();
  assign fa_if.raw = pin_s2_q[0];
  assign fa_if.div_sel = pdiv_q;
  assign fa_if.en = pen_q;
  assign fb_if.raw = pin_s2_q[1];
  assign fb_if.div_sel = pdiv_q;
  assign fb_if.en = pen_q;
  assign fi_if.raw = pin_s2_q[2];
  assign fi_if.div_sel = idiv_q;
  assign fi_if.en = ien_q;
  qen_filter u_fa (.clock(clock), .rst_n(rst_n_q), .port(fa_if.flt));
  qen_filter u_fb (.clock(clock), .rst_n(rst_n_q), .port(fb_if.flt));
  qen_filter u_fi (.clock(clock), .rst_n(rst_n_q), .port(fi_if.flt));
  assign fa = fa_if.filt;
  assign fb = fb_if.filt;
  assign fi = fi_if.filt;

  assign qa = swap_q ? fb : fa;
  assign qb = swap_q ? fa : fb;
  assign a_edge = qa ^ qa_q;
  assign b_edge = qb ^ qb_q;
  assign up_w = qa ^ qb_q;
  // mode decode; 010 and 011 fall out as disabled
  assign enc_mode = mode_q[2];
  assign x4 = mode_q[1];
  assign match = mode_q[0];
  assign tmr_mode = (mode_q == QEN_MODE_TMR);
  assign halt = cpu_idle & sidl_q;
  // x4 both phases, x2 phase a only
  assign enc_step = enc_mode & ~halt & (x4 ? (a_edge | b_edge) : a_edge);
  assign idx_rst = enc_mode & ~match & ~halt & fi & ~idx_prev_q;

  assign tck_rise = pin_s2_q[3] & ~tck_prev_q;
  assign src_tick = cs_q ? (sync_q ? tck_rise_q : tck_rise) : 1'b1;
  // gate holds the count while low
  assign gate_ok = ~gate_en_q | pin_s2_q[4];
  assign ps_tick = tmr_mode & ~halt & src_tick & gate_ok & (ps_q == qen_ps_tc(ps_sel_q));
  assign tmr_tick = ps_tick;
  assign tmr_up = dsrc_q ? pin_s2_q[1] : dir_q;
  // gate falling edge ends an accumulation
  assign gate_evt = tmr_mode & gate_en_q & ~halt & gate_prev_q & ~pin_s2_q[4];

  assign enc_evt = enc_step & ~idx_rst &
                   (up_w ? (pos_q == QEN_CNT_TOP || (match && pos_q == max_q))
                         : (pos_q == QEN_CNT_ZERO));
  assign tmr_evt = tmr_tick & (tmr_up ? (pos_q == max_q) : (pos_q == QEN_CNT_ZERO));
  assign evt = enc_evt | tmr_evt | gate_evt;

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      qa_q <= 1'b0;
      qb_q <= 1'b0;
      idx_prev_q <= 1'b0;
      tck_prev_q <= 1'b0;
      tck_rise_q <= 1'b0;
      gate_prev_q <= 1'b0;
      idx_st_q <= 1'b0;
    end else begin
      qa_q <= qa;
      qb_q <= qb;
      idx_prev_q <= fi;
      tck_prev_q <= pin_s2_q[3];
      tck_rise_q <= tck_rise;
      gate_prev_q <= pin_s2_q[4];
      idx_st_q <= pin_s2_q[2];
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ps_q <= 8'h00;
    end else if (!tmr_mode || wr_pos) begin
      ps_q <= 8'h00;
    end else if (tmr_mode && !halt && src_tick && gate_ok) begin
      ps_q <= ps_tick ? 8'h00 : ps_q + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pos_q <= QEN_POS_RST;
    end else if (wr_pos) begin
      pos_q <= hwdata[15:0];
    end else if (idx_rst) begin
      pos_q <= QEN_CNT_ZERO;
    end else if (enc_step) begin
      if (up_w) begin
        pos_q <= (match && pos_q == max_q) ? QEN_CNT_ZERO : pos_q + 16'h0001;
      end else begin
        pos_q <= (match && pos_q == QEN_CNT_ZERO) ? max_q : pos_q - 16'h0001;
      end
    end else if (tmr_tick) begin
      if (tmr_up) begin
        pos_q <= (pos_q == max_q) ? QEN_CNT_ZERO : pos_q + 16'h0001;
      end else begin
        pos_q <= (pos_q == QEN_CNT_ZERO) ? max_q : pos_q - 16'h0001;
      end
    end
  end

  // direction status, software owns it only in timer mode
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dir_q <= QEN_CTL_RST[QEN_CTL_DIR];
    end else if (wr_ctl && hwdata[QEN_CTL_MODE +: 3] == QEN_MODE_TMR) begin
      dir_q <= hwdata[QEN_CTL_DIR];
    end else if (enc_step) begin
      dir_q <= up_w;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sidl_q <= QEN_CTL_RST[QEN_CTL_SIDL];
      mode_q <= QEN_CTL_RST[QEN_CTL_MODE +: 3];
      swap_q <= QEN_CTL_RST[QEN_CTL_SWAP];
      doe_q <= QEN_CTL_RST[QEN_CTL_DOE];
      gate_en_q <= QEN_CTL_RST[QEN_CTL_GATE];
      ps_sel_q <= QEN_CTL_RST[QEN_CTL_PS +: 2];
      sync_q <= QEN_CTL_RST[QEN_CTL_SYNC];
      cs_q <= QEN_CTL_RST[QEN_CTL_CS];
      dsrc_q <= QEN_CTL_RST[QEN_CTL_DSRC];
    end else if (wr_ctl) begin
      sidl_q <= hwdata[QEN_CTL_SIDL];
      mode_q <= hwdata[QEN_CTL_MODE +: 3];
      swap_q <= hwdata[QEN_CTL_SWAP];
      doe_q <= hwdata[QEN_CTL_DOE];
      gate_en_q <= hwdata[QEN_CTL_GATE];
      ps_sel_q <= hwdata[QEN_CTL_PS +: 2];
      sync_q <= hwdata[QEN_CTL_SYNC];
      cs_q <= hwdata[QEN_CTL_CS];
      dsrc_q <= hwdata[QEN_CTL_DSRC];
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pen_q <= QEN_FLT_RST[QEN_FLT_PEN];
      pdiv_q <= QEN_FLT_RST[QEN_FLT_PDIV +: 3];
      ien_q <= QEN_FLT_RST[QEN_FLT_IEN];
      idiv_q <= QEN_FLT_RST[QEN_FLT_IDIV +: 3];
    end else if (wr_flt) begin
      pen_q <= hwdata[QEN_FLT_PEN];
      pdiv_q <= hwdata[QEN_FLT_PDIV +: 3];
      ien_q <= hwdata[QEN_FLT_IEN];
      idiv_q <= hwdata[QEN_FLT_IDIV +: 3];
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      max_q <= QEN_MAX_RST;
    end else if (wr_max) begin
      max_q <= hwdata[15:0];
    end
  end

  // sticky flag; a same-cycle event beats the clear
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flag_q <= 1'b0;
    end else if (evt) begin
      flag_q <= 1'b1;
    end else if (wr_irq && hwdata[QEN_IRQ_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_en_q <= 1'b0;
    end else if (wr_irq) begin
      irq_en_q <= hwdata[QEN_IRQ_EN];
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      encoder_irq <= 1'b0;
      dir_oe <= 1'b0;
      dir_out <= 1'b0;
    end else begin
      encoder_irq <= flag_q & irq_en_q;
      dir_oe <= doe_q;
      dir_out <= dir_q;
    end
  end

  assign addr_ok = hsel & hready & htrans[1];
  assign sel_w = {haddr == QEN_ADDR_IRQ, haddr == QEN_ADDR_MAX, haddr == QEN_ADDR_POS,
                  haddr == QEN_ADDR_FLT, haddr == QEN_ADDR_CTL};
  assign wr_ctl = wr_q & sel_q[0];
  assign wr_flt = wr_q & sel_q[1];
  assign wr_pos = wr_q & sel_q[2];
  assign wr_max = wr_q & sel_q[3];
  assign wr_irq = wr_q & sel_q[4];

  always_comb begin
    rdata_w = 32'h00000000;
    case (1'b1)
      sel_q[0]: begin
        rdata_w[QEN_CTL_SIDL] = sidl_q;
        rdata_w[QEN_CTL_INDEX_PIN_STATE] = idx_st_q;
        rdata_w[QEN_CTL_DIR] = dir_q;
        rdata_w[QEN_CTL_MODE +: 3] = mode_q;
        rdata_w[QEN_CTL_SWAP] = swap_q;
        rdata_w[QEN_CTL_DOE] = doe_q;
        rdata_w[QEN_CTL_GATE] = gate_en_q;
        rdata_w[QEN_CTL_PS +: 2] = ps_sel_q;
        rdata_w[QEN_CTL_SYNC] = sync_q;
        rdata_w[QEN_CTL_CS] = cs_q;
        rdata_w[QEN_CTL_DSRC] = dsrc_q;
      end
      sel_q[1]: begin
        rdata_w[QEN_FLT_PEN] = pen_q;
        rdata_w[QEN_FLT_PDIV +: 3] = pdiv_q;
        rdata_w[QEN_FLT_IEN] = ien_q;
        rdata_w[QEN_FLT_IDIV +: 3] = idiv_q;
      end
      sel_q[2]: rdata_w[15:0] = pos_q;
      sel_q[3]: rdata_w[15:0] = max_q;
      sel_q[4]: begin
        rdata_w[QEN_IRQ_FLAG] = flag_q;
        rdata_w[QEN_IRQ_EN] = irq_en_q;
      end
      default: rdata_w = 32'h00000000;
    endcase
  end

  // read waits one cycle so a write just ahead of it is already stored
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= QEN_BUS_IDLE;
      wr_q <= 1'b0;
      sel_q <= 5'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= QEN_HRESP_OKAY;
    end else begin
      hresp <= QEN_HRESP_OKAY;
      case (st_q)
        QEN_BUS_IDLE: begin
          wr_q <= addr_ok & hwrite;
          if (addr_ok) begin
            sel_q <= sel_w;
          end
          if (addr_ok && !hwrite) begin
            st_q <= QEN_BUS_RD;
            hreadyout <= 1'b0;
          end
        end
        QEN_BUS_RD: begin
          wr_q <= 1'b0;
          hrdata <= rdata_w;
          hreadyout <= 1'b1;
          st_q <= QEN_BUS_IDLE;
        end
        default: begin
          st_q <= QEN_BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n_q)
    (flag_q && !(wr_irq && hwdata[QEN_IRQ_FLAG])) |=> flag_q)
    else $error("flag dropped without software clear");
  a_irq_gate: assert property (@(posedge clock) disable iff (!rst_n_q)
    encoder_irq |-> $past(flag_q) && $past(irq_en_q))
    else $error("request raised while disabled");
  a_roll_flag: assert property (@(posedge clock) disable iff (!rst_n_q)
    (enc_step && up_w && pos_q == QEN_CNT_TOP && !wr_pos && !idx_rst) |=>
    flag_q ##1 encoder_irq == $past(irq_en_q))
    else $error("rollover did not set flag");
  a_idle_halt: assert property (@(posedge clock) disable iff (!rst_n_q)
    (halt && !wr_pos) |=> $stable(pos_q))
    else $error("counter moved while halted in idle");
  a_mode_off: assert property (@(posedge clock) disable iff (!rst_n_q)
    (mode_q[2:1] == 2'h1 && !wr_pos) |=> $stable(pos_q))
    else $error("unused mode changed counter");
  a_max_wrap: assert property (@(posedge clock) disable iff (!rst_n_q)
    (enc_step && match && up_w && pos_q == max_q && !wr_pos) |=> pos_q == QEN_CNT_ZERO)
    else $error("match mode did not reset counter");
  a_x2_phase: assert property (@(posedge clock) disable iff (!rst_n_q)
    (enc_mode && !x4 && !a_edge && !wr_pos && !idx_rst) |=> $stable(pos_q))
    else $error("x2 mode counted without phase a edge");
  a_dir_pin: assert property (@(posedge clock) disable iff (!rst_n_q)
    $rose(doe_q) |=> dir_oe ##0 dir_out == $past(dir_q))
    else $error("direction pin not driven");
  a_read_wait: assert property (@(posedge clock) disable iff (!rst_n_q)
    (st_q == QEN_BUS_IDLE && addr_ok && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  c_rollover: cover property (@(posedge clock) disable iff (!rst_n_q) enc_evt);
  c_timer_match: cover property (@(posedge clock) disable iff (!rst_n_q) tmr_evt);
  c_gate_end: cover property (@(posedge clock) disable iff (!rst_n_q) gate_evt);
  c_index_reset: cover property (@(posedge clock) disable iff (!rst_n_q) idx_rst);
endmodule

// ---- bench/qen_enc_model.sv ----
// Purpose: incremental encoder model, two phases and index
// Assumes: forward means phase A leads phase B
// Notes: pins are levels that stay steady between steps
`timescale 1ns/10ps
module qen_enc_model (
  input wire logic clock,
  output logic phase_a,
  output logic phase_b,
  output logic index
);
  int ph;
  initial begin
    ph = 0;
    phase_a = 1'b0;
    phase_b = 1'b0;
    index = 1'b0;
  end
  // one gray step; long settle covers sync flops and edge logic
  task automatic step(input bit fwd);
    @(posedge clock);
    ph = fwd ? (ph + 1) % 4 : (ph + 3) % 4;
    phase_a <= (ph == 1) || (ph == 2);
    phase_b <= (ph >= 2);
    repeat (8) @(posedge clock);
  endtask
  task automatic mark(input logic v);
    @(posedge clock);
    index <= v;
    repeat (6) @(posedge clock);
  endtask
endmodule

// ---- bench/testbench.sv ----
// Purpose: self-checking bench for the encoder block
// Assumes: AHB-Lite master tasks, encoder model on the pins
// Notes: gate and external clock pins driven by the bench for the timer scenario
`timescale 1ns/10ps
module testbench;
  import qen_pkg::*;
  logic clock, nrst, hsel, hwrite, hreadyout, cpu_idle, dir_out, dir_oe, encoder_irq;
  logic pa, pb, ix, tck, gate;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, hresp;
  int errors, cmp_count, cycles;
  qen_top dut_u (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .phase_a_input(pa), .phase_b_input(pb),
    .index_input(ix), .timer_ext_clock_pin(tck), .timer_gate_input(gate),
    .cpu_idle(cpu_idle), .dir_out(dir_out), .dir_oe(dir_oe), .encoder_irq(encoder_irq));
  qen_enc_model enc_u (.clock(clock), .phase_a(pa), .phase_b(pb), .index(ix));
  always #12.5 clock = ~clock;
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ceiling well above the fewer than one thousand cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("ERROR %0t: timeout", $time);
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    // no own limit: only the bench timeout ends a hung wait
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic t_reset();
    rdc(QEN_ADDR_CTL, 32'h0000);
    rdc(QEN_ADDR_FLT, 32'h0000);
    rdc(QEN_ADDR_POS, 32'h0000);
    rdc(QEN_ADDR_MAX, 32'hFFFF);
    rdc(32'h0000_0500, 32'h0000);
    wr(QEN_ADDR_FLT, 32'h00FF);
    rdc(QEN_ADDR_FLT, 32'h00FF);
    wr(QEN_ADDR_FLT, 32'h0000);
    $display("test reset done");
  endtask
  task automatic t_x4();
    wr(QEN_ADDR_CTL, 32'h0740);
    repeat (4) enc_u.step(1'b1);
    rdc(QEN_ADDR_POS, 32'h0004);
    rdc(QEN_ADDR_CTL, 32'h0F40);
    chk({30'h0, dir_oe, dir_out}, 32'h3);
    wr(QEN_ADDR_CTL, 32'h07C0);
    repeat (2) enc_u.step(1'b1);
    rdc(QEN_ADDR_POS, 32'h0002);
    chk({31'h0, dir_out}, 32'h0);
    $display("test x4 done");
  endtask
  task automatic t_x2();
    wr(QEN_ADDR_CTL, 32'h0500);
    repeat (4) enc_u.step(1'b1);
    rdc(QEN_ADDR_POS, 32'h0004);
    repeat (4) enc_u.step(1'b0);
    rdc(QEN_ADDR_POS, 32'h0002);
    wr(QEN_ADDR_POS, 32'h1234);
    wr(QEN_ADDR_CTL, 32'h0400);
    enc_u.mark(1'b1);
    rdc(QEN_ADDR_CTL, 32'h1400);
    rdc(QEN_ADDR_POS, 32'h0000);
    enc_u.mark(1'b0);
    $display("test x2 done");
  endtask
  task automatic t_roll();
    wr(QEN_ADDR_IRQ, 32'h0002);
    wr(QEN_ADDR_POS, 32'hFFFF);
    wr(QEN_ADDR_CTL, 32'h0600);
    enc_u.step(1'b1);
    rdc(QEN_ADDR_POS, 32'h0000);
    rdc(QEN_ADDR_IRQ, 32'h0003);
    chk({31'h0, encoder_irq}, 32'h1);
    wr(QEN_ADDR_IRQ, 32'h0000);
    rdc(QEN_ADDR_IRQ, 32'h0001);
    chk({31'h0, encoder_irq}, 32'h0);
    wr(QEN_ADDR_IRQ, 32'h0001);
    rdc(QEN_ADDR_IRQ, 32'h0000);
    enc_u.step(1'b0);
    rdc(QEN_ADDR_IRQ, 32'h0001);
    $display("test rollover done");
  endtask
  task automatic t_timer();
    wr(QEN_ADDR_IRQ, 32'h0001);
    wr(QEN_ADDR_MAX, 32'h0010);
    wr(QEN_ADDR_POS, 32'h0000);
    cpu_idle <= 1'b1;
    wr(QEN_ADDR_CTL, 32'h2900);
    repeat (40) @(posedge clock);
    rdc(QEN_ADDR_POS, 32'h0000);
    cpu_idle <= 1'b0;
    repeat (30) @(posedge clock);
    rdc(QEN_ADDR_IRQ, 32'h0001);
    // slowest prescale: no tick inside a hundred cycles
    wr(QEN_ADDR_CTL, 32'h0918);
    wr(QEN_ADDR_POS, 32'h0000);
    repeat (100) @(posedge clock);
    rdc(QEN_ADDR_POS, 32'h0000);
    wr(QEN_ADDR_CTL, 32'h0000);
    $display("test timer done");
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clock);
      tck <= 1'b1;
      repeat (4) @(posedge clock);
      tck <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
  task automatic t_ext();
    wr(QEN_ADDR_IRQ, 32'h0001);
    wr(QEN_ADDR_MAX, 32'h0003);
    wr(QEN_ADDR_POS, 32'h0000);
    // external clock, unsynchronised, direction bit up
    wr(QEN_ADDR_CTL, 32'h0902);
    pulse(3);
    rdc(QEN_ADDR_POS, 32'h0003);
    rdc(QEN_ADDR_IRQ, 32'h0000);
    pulse(1);
    rdc(QEN_ADDR_POS, 32'h0000);
    rdc(QEN_ADDR_IRQ, 32'h0001);
    wr(QEN_ADDR_IRQ, 32'h0001);
    // synchronised clock, gated, direction from phase b (high)
    wr(QEN_ADDR_CTL, 32'h0127);
    pulse(2);
    rdc(QEN_ADDR_POS, 32'h0000);
    gate <= 1'b1;
    pulse(2);
    rdc(QEN_ADDR_POS, 32'h0002);
    rdc(QEN_ADDR_IRQ, 32'h0000);
    gate <= 1'b0;
    repeat (6) @(posedge clock);
    rdc(QEN_ADDR_IRQ, 32'h0001);
    wr(QEN_ADDR_CTL, 32'h0300);
    repeat (2) enc_u.step(1'b1);
    rdc(QEN_ADDR_POS, 32'h0002);
    wr(QEN_ADDR_FLT, 32'h0080);
    wr(QEN_ADDR_CTL, 32'h0600);
    repeat (2) enc_u.step(1'b1);
    rdc(QEN_ADDR_POS, 32'h0004);
    wr(QEN_ADDR_FLT, 32'h0000);
    wr(QEN_ADDR_CTL, 32'h0000);
    $display("test external done");
  endtask
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    cpu_idle = 1'b0;
    tck = 1'b0;
    gate = 1'b0;
    hsize = 3'h2;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_x4();
    t_x2();
    t_roll();
    t_timer();
    t_ext();
    tally_and_finish();
  end
endmodule
